// File: hdl/sf_status_consts.vh
/*
 * Constants for the serial flash status and protection block: opcodes,
 * status bit positions and reset values.
 * Assumes inclusion by bare name from design files under hdl/.
 */
`ifndef SF_STATUS_CONSTS_VH
`define SF_STATUS_CONSTS_VH

// ************************************************************
// Opcodes
// ************************************************************
`define OP_WRITE_LOCK    8'h04
`define OP_WRITE_UNLOCK  8'h06
`define OP_STATUS_READ   8'h05
`define OP_STATUS2_RD_A  8'h09
`define OP_STATUS2_RD_B  8'h35
`define OP_STATUS_WRITE  8'h01
`define OP_PAGE_WRITE    8'h02
`define OP_QPAGE_WRITE   8'h32
`define OP_SECTOR_WIPE   8'h20
`define OP_HALF_WIPE     8'h52
`define OP_FULL_WIPE     8'hd8
`define OP_CHIP_WIPE_A   8'hc7
`define OP_CHIP_WIPE_B   8'h60

// ************************************************************
// Status register 1 bit positions
// ************************************************************
`define SR1_BUSY    0
`define SR1_LATCH   1
`define SR1_RGN_LO  2
`define SR1_RGN_HI  4
`define SR1_LOWEND  5
`define SR1_GRAN    6
`define SR1_LOCK    7

// ************************************************************
// Status register 2 bit positions
// ************************************************************
`define SR2_RSVD    0
`define SR2_QUAD    1
`define SR2_PPAUSE  2
`define SR2_OTP_LO  3
`define SR2_OTP_HI  5
`define SR2_INVERT  6
`define SR2_EPAUSE  7

// ************************************************************
// Reset values of the stored bits
// ************************************************************
`define SR1_NV_RESET  6'h00
`define INVERT_RESET  1'b0
`define QUAD_RESET    1'b1
`define OTP_RESET     3'h0

// Frame decode
`define OPC_BITS     8
`define BITCNT_W     4
`define CMD_LAST     4'h7
`define NIB_LAST     4'h1
// Data units after the opcode: the counter saturates so long frames never alias
`define WCNT_MAX      5'h1f
`define DATA_ONE      5'h08
`define DATA_TWO      5'h10
`define NIB_DATA_ONE  5'h02
`define NIB_DATA_TWO  5'h04
`define ZERO3        3'h0

`endif

// File: hdl/sf_status_protect.v
/*
 * Status and write-protection logic of a serial flash, as a single
 * SPI-facing block. Serial clock edges arrive as one-cycle pulses on
 * sys_clk_in (rise/fall enables) with chip select and data sampled
 * synchronously. Array operations are outside; this block accepts or
 * refuses them and tracks busy, suspend and protection state.
 */
`include "sf_status_consts.vh"

module sf_status_protect (
	// Clock and reset
	input  wire       sys_clk_in,
	input  wire       nrst_in,
	// Serial link, edges as enables
	input  wire       cs_n_in,
	input  wire       sclk_rise_in,
	input  wire       sclk_fall_in,
	input  wire [3:0] serial_in_pin_in,
	input  wire       write_guard_n_in,
	input  wire       four_wire_cmd_mode_in,
	output wire [3:0] data_out,
	output wire [3:0] data_oe_out,
	// Array engine
	input  wire       op_done_in,
	input  wire       suspend_in,
	input  wire       resume_in,
	input  wire       target_protected_in,
	output reg        op_start_out,
	output reg  [7:0] op_code_out,
	// Protection view for the array engine
	output wire [2:0] region_size_out,
	output wire       protect_from_low_end_out,
	output wire       small_granule_lock_out,
	output wire       invert_protect_region_out,
	output wire [2:0] otp_lock_out,
	output wire       quad_pins_claim_out,
	output wire       guard_pin_active_out
);

	// ************************************************************
	// State
	// ************************************************************
	reg  [5:0] sr1_nv_q;     // Bits 7..2
	reg        latch_q;
	reg        busy_q;
	reg        invert_q;
	reg        quad_q;
	reg  [2:0] otp_q;
	reg        epause_q;
	reg        ppause_q;
	reg        op_is_erase_q;
	reg  [7:0] opc_q;
	reg  [3:0] cnt_q;
	reg        have_opc_q;
	reg  [15:0] wdata_q;
	reg  [4:0] wcnt_q;       // Data units seen, saturating
	reg  [1:0] rd_sel_q;     // 0 none, 1 status1, 2 status2
	reg  [7:0] shift_q;
	reg  [2:0] bit_q;
	reg        oe_q;
	reg        cs_n_q;

	wire [7:0] sr1 = {sr1_nv_q, latch_q, busy_q};
	wire [7:0] sr2 = {epause_q, invert_q, otp_q, ppause_q, quad_q, 1'b0};
	// Guard pin only counts while quad pins are not claimed
	wire       guard_low = ~write_guard_n_in & ~quad_q;
	wire       hw_protect = sr1_nv_q[`SR1_LOCK-2] & guard_low;
	wire       quad = four_wire_cmd_mode_in;
	wire       cs_rise = cs_n_in & ~cs_n_q;
	wire [7:0] opc_next = quad ? {opc_q[3:0], serial_in_pin_in}
				   : {opc_q[6:0], serial_in_pin_in[0]};
	wire       opc_end = ~have_opc_q & sclk_rise_in & ~cs_n_in &
			     (cnt_q == (quad ? `NIB_LAST : `CMD_LAST));

	function is_array_op;
		input [7:0] c;
		begin
			is_array_op = (c == `OP_PAGE_WRITE) || (c == `OP_QPAGE_WRITE) ||
				      (c == `OP_SECTOR_WIPE) || (c == `OP_HALF_WIPE) ||
				      (c == `OP_FULL_WIPE);
		end
	endfunction

	function is_chip_wipe;
		input [7:0] c;
		begin
			is_chip_wipe = (c == `OP_CHIP_WIPE_A) || (c == `OP_CHIP_WIPE_B);
		end
	endfunction

	assign region_size_out           = sr1_nv_q[`SR1_RGN_HI-2:`SR1_RGN_LO-2];
	assign protect_from_low_end_out  = sr1_nv_q[`SR1_LOWEND-2];
	assign small_granule_lock_out    = sr1_nv_q[`SR1_GRAN-2];
	assign invert_protect_region_out = invert_q;
	assign otp_lock_out              = otp_q;
	assign quad_pins_claim_out       = quad_q;
	assign guard_pin_active_out      = ~quad_q;

	// ************************************************************
	// Frame decode: opcode and status-write data capture
	// ************************************************************
	always @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cs_n_q     <= 1'b1;
			opc_q      <= 8'h00;
			cnt_q      <= 4'h0;
			have_opc_q <= 1'b0;
			wdata_q    <= 16'h0000;
			wcnt_q     <= 5'h00;
		end else begin
			cs_n_q <= cs_n_in;
			if (cs_n_in) begin
				cnt_q      <= 4'h0;
				have_opc_q <= 1'b0;
				wcnt_q     <= 5'h00;
			end else if (sclk_rise_in) begin
				if (!have_opc_q) begin
					opc_q <= opc_next;
					cnt_q <= cnt_q + 4'h1;
					if (opc_end)
						have_opc_q <= 1'b1;
				end else begin
					// Data after the opcode; only status write needs it
					wdata_q <= quad ? {wdata_q[11:0], serial_in_pin_in}
							: {wdata_q[14:0], serial_in_pin_in[0]};
					if (wcnt_q != `WCNT_MAX)
						wcnt_q <= wcnt_q + 5'h01;
				end
			end
		end
	end

	// ************************************************************
	// Status bits, command acceptance and array handoff
	// ************************************************************
	// Commands execute at chip select rise, as the frame then is whole
	wire do_status_write_cmd = cs_rise & have_opc_q & (opc_q == `OP_STATUS_WRITE) & latch_q &
		       ~busy_q & ~hw_protect &
		       ((wcnt_q == (quad ? `NIB_DATA_ONE : `DATA_ONE)) ||
			(wcnt_q == (quad ? `NIB_DATA_TWO : `DATA_TWO)));
	wire two_bytes = (wcnt_q == (quad ? `NIB_DATA_TWO : `DATA_TWO));
	wire [7:0] w1 = two_bytes ? wdata_q[15:8] : wdata_q[7:0];
	wire [7:0] w2 = wdata_q[7:0];
	wire do_array = cs_rise & have_opc_q & latch_q & ~busy_q &
			((is_array_op(opc_q) & ~target_protected_in) |
			 (is_chip_wipe(opc_q) &
			  (sr1_nv_q[`SR1_RGN_HI-2:`SR1_RGN_LO-2] == `ZERO3)));

	always @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sr1_nv_q      <= `SR1_NV_RESET;
			latch_q       <= 1'b0;
			busy_q        <= 1'b0;
			invert_q      <= `INVERT_RESET;
			quad_q        <= `QUAD_RESET;
			otp_q         <= `OTP_RESET;
			epause_q      <= 1'b0;
			ppause_q      <= 1'b0;
			op_is_erase_q <= 1'b0;
			op_start_out  <= 1'b0;
			op_code_out   <= 8'h00;
		end else begin
			op_start_out <= 1'b0;
			if (cs_rise && have_opc_q && opc_q == `OP_WRITE_LOCK)
				latch_q <= 1'b0;
			if (cs_rise && have_opc_q && opc_q == `OP_WRITE_UNLOCK)
				latch_q <= 1'b1;
			if (do_status_write_cmd) begin
				// Region bits guarded by hardware protect via do_status_write_cmd
				sr1_nv_q <= w1[7:2];
				busy_q   <= 1'b1;
				op_start_out <= 1'b1;
				op_code_out  <= opc_q;
				if (two_bytes) begin
					invert_q <= w2[`SR2_INVERT];
					quad_q   <= w2[`SR2_QUAD];
					otp_q    <= otp_q | w2[`SR2_OTP_HI:`SR2_OTP_LO];
				end
			end
			if (do_array) begin
				busy_q        <= 1'b1;
				op_start_out  <= 1'b1;
				op_code_out   <= opc_q;
				op_is_erase_q <= ~((opc_q == `OP_PAGE_WRITE) ||
						  (opc_q == `OP_QPAGE_WRITE));
			end
			if (busy_q && op_done_in) begin
				busy_q  <= 1'b0;
				latch_q <= 1'b0;
			end
			// Suspend pauses the busy cycle; resume restarts it
			if (busy_q && suspend_in) begin
				busy_q <= 1'b0;
				if (op_is_erase_q)
					epause_q <= 1'b1;
				else
					ppause_q <= 1'b1;
			end
			if (resume_in && (epause_q || ppause_q)) begin
				busy_q   <= 1'b1;
				epause_q <= 1'b0;
				ppause_q <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Status readout, repeated while selected
	// ************************************************************
	// Byte is reloaded at each boundary so a poll sees live busy
	always @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rd_sel_q <= 2'b00;
			shift_q  <= 8'h00;
			bit_q    <= 3'h0;
			oe_q     <= 1'b0;
		end else if (cs_n_in) begin
			rd_sel_q <= 2'b00;
			oe_q     <= 1'b0;
			bit_q    <= 3'h0;
		end else if (opc_end) begin
			if (opc_next == `OP_STATUS_READ)
				rd_sel_q <= 2'b01;
			else if (opc_next == `OP_STATUS2_RD_A || opc_next == `OP_STATUS2_RD_B)
				rd_sel_q <= 2'b10;
		end else if (sclk_fall_in && rd_sel_q != 2'b00) begin
			oe_q <= 1'b1;
			if (bit_q == 3'h0 || (quad && bit_q == 3'h4)) begin
				// Reload at byte start, then advance MSB first
				if (bit_q == 3'h0)
					shift_q <= (rd_sel_q == 2'b01) ? sr1 : sr2;
				else
					shift_q <= {shift_q[3:0], 4'h0};
			end else
				shift_q <= {shift_q[6:0], 1'b0};
			bit_q <= quad ? bit_q + 3'h4 : bit_q + 3'h1;
		end
	end

	assign data_out    = quad ? shift_q[7:4] : {2'b00, shift_q[7], 1'b0};
	assign data_oe_out = quad ? {4{oe_q}} : {2'b00, oe_q, 1'b0};

endmodule

// File: bench/host_flash_master.sv
/* Host controller model that drives select frames into the status block.
   Assumes the bench owns clock, reset and the nibble framing level. */
module host_flash_master (
	// Clock and returned data
	input  logic       clk_in,
	input  logic       quad_in,
	input  logic [3:0] data_in,
	// Link drive
	output logic       cs_n_out = 1'b1,
	output logic       rise_out = 1'b0,
	output logic       fall_out = 1'b0,
	output logic [3:0] din_out = 4'h0
);
	timeunit 1ns;
	timeprecision 1ps;

	// One frame: opcode, nd data bits MSB first, nrd bytes read back
	task automatic frame(input [7:0] op, input [31:0] d, input int nd, input int nrd,
			output logic [15:0] rd);
		logic [47:0] sr;
		int w;
		int n;
		w = quad_in ? 4 : 1;
		n = (8 + nd + 8 * nrd) / w;
		sr = {op, d << (32 - nd), 8'h00};
		rd = 16'h0;
		@(posedge clk_in) #1 cs_n_out = 1'b0;
		for (int u = 0; u < n; u++) begin
			@(posedge clk_in) #1 din_out = quad_in ? sr[47:44] : {3'h0, sr[47]};
			rise_out = 1'b1;
			sr = sr << w;
			@(posedge clk_in) #1 rise_out = 1'b0;
			fall_out = 1'b1;
			@(posedge clk_in) #1 fall_out = 1'b0;
			if (u >= 8 / w - 1 && u < n - 1)
				rd = quad_in ? {rd[11:0], data_in} : {rd[14:0], data_in[1]};
		end
		@(posedge clk_in) #1 cs_n_out = 1'b1;
		// Released input shows a changed level, never a stale bit
		din_out = ~din_out;
		repeat (3) @(posedge clk_in);
	endtask
endmodule

// File: bench/sf_status_protect_chk.sv
/* Port checks for the status and protection block.
   Assumes one clock and an asynchronous active-low reset. */
module sf_status_protect_chk (
	// Clock, reset and link
	input logic       sys_clk_in,
	input logic       nrst_in,
	input logic       cs_n_in,
	input logic [3:0] data_oe_out,
	// Engine and protection view
	input logic       op_start_out,
	input logic [7:0] op_code_out,
	input logic [2:0] region_size_out,
	input logic [2:0] otp_lock_out,
	input logic       quad_pins_claim_out,
	input logic       guard_pin_active_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);

	chk_oe_release: assert property ($rose(cs_n_in) |-> ##[1:2] data_oe_out == 4'h0)
		else $error("output enable held after deselect");
	chk_oe_shape: assert property (data_oe_out inside {4'h0, 4'h2, 4'hf})
		else $error("output enable pattern not single or nibble");
	chk_start_pulse: assert property (op_start_out |=> !op_start_out)
		else $error("start pulse longer than one cycle");
	chk_start_deselect: assert property (op_start_out |-> cs_n_in && $past(cs_n_in))
		else $error("command started while selected");
	chk_start_kind: assert property (op_start_out |-> op_code_out inside
		{8'h01, 8'h02, 8'h32, 8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60})
		else $error("start for a command that writes nothing");
	chk_chip_clear: assert property (op_start_out && op_code_out inside {8'hc7, 8'h60}
		|-> region_size_out == 3'h0) else $error("chip wipe with region bits set");
	chk_otp_sticky: assert property (($past(otp_lock_out) & ~otp_lock_out) == 3'h0)
		else $error("one-time lock cleared");
	chk_region_deselect: assert property ($changed(region_size_out) |-> $past(cs_n_in))
		else $error("region bits changed inside a frame");
	chk_guard_quad: assert property (quad_pins_claim_out |-> !guard_pin_active_out)
		else $error("guard pin active while quad bit set");

	cov_status_write: cover property (op_start_out && op_code_out == 8'h01);
	cov_erase: cover property (op_start_out && op_code_out == 8'h20);
	cov_nibble_out: cover property (data_oe_out == 4'hf);
endmodule

bind sf_status_protect sf_status_protect_chk chk (.sys_clk_in, .nrst_in, .cs_n_in, .data_oe_out,
	.op_start_out, .op_code_out, .region_size_out, .otp_lock_out, .quad_pins_claim_out,
	.guard_pin_active_out);

// File: bench/serial_flash_status_protect_bench.sv
/* Self-checking bench for the status and protection block.
   Assumes the host model and checker files are compiled first. */
module serial_flash_status_protect_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_in = 1'b0, nrst_in = 1'b0, four_wire_cmd_mode_in = 1'b0, write_guard_n_in = 1'b1;
	logic op_done_in = 1'b0, suspend_in = 1'b0, resume_in = 1'b0, target_protected_in = 1'b0;
	logic cs_n_in, sclk_rise_in, sclk_fall_in, op_start_out, protect_from_low_end_out;
	logic small_granule_lock_out, invert_protect_region_out, quad_pins_claim_out;
	logic guard_pin_active_out;
	logic [3:0] serial_in_pin_in, data_out, data_oe_out;
	logic [7:0] op_code_out;
	logic [2:0] region_size_out, otp_lock_out;
	logic [15:0] rd;
	int mismatches = 0, checks = 0, starts = 0;

	// ****************************************
	// Clock, design and host model
	// ****************************************
	always #10 sys_clk_in = ~sys_clk_in;
	always @(posedge sys_clk_in) if (op_start_out === 1'b1) starts++;
	sf_status_protect dut (.sys_clk_in, .nrst_in, .cs_n_in, .sclk_rise_in, .sclk_fall_in,
		.serial_in_pin_in, .write_guard_n_in, .four_wire_cmd_mode_in, .data_out, .data_oe_out,
		.op_done_in, .suspend_in, .resume_in, .target_protected_in, .op_start_out, .op_code_out,
		.region_size_out, .protect_from_low_end_out, .small_granule_lock_out,
		.invert_protect_region_out, .otp_lock_out, .quad_pins_claim_out, .guard_pin_active_out);
	host_flash_master host (.clk_in(sys_clk_in), .quad_in(four_wire_cmd_mode_in), .data_in(data_out),
		.cs_n_out(cs_n_in), .rise_out(sclk_rise_in), .fall_out(sclk_fall_in),
		.din_out(serial_in_pin_in));

	task automatic expect_eq(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cmd(input [7:0] op, input [31:0] d = 0, input int nd = 0, input int nrd = 0);
		host.frame(op, d, nd, nrd, rd);
	endtask
	// Engine strobe: 0 done, 1 suspend, 2 resume
	task automatic pulse(input int k);
		@(posedge sys_clk_in) #1 {resume_in, suspend_in, op_done_in} = 3'h1 << k;
		@(posedge sys_clk_in) #1 {resume_in, suspend_in, op_done_in} = 3'h0;
		repeat (2) @(posedge sys_clk_in);
	endtask
	// Two bytes in one frame, so a non-repeating byte shows up
	task automatic rd_status(input [7:0] op, input [7:0] m, input [7:0] exp, input string what);
		cmd(op, 0, 0, 2);
		expect_eq(what, {exp & m, exp & m}, rd & {m, m});
	endtask
	task automatic t_reset;
		rd_status(8'h05, 8'hff, 8'h00, "status1 reset");
		rd_status(8'h09, 8'hff, 8'h02, "status2 reset");
		rd_status(8'h35, 8'hfe, 8'h02, "status2 alt opcode");
	endtask
	task automatic t_latch;
		cmd(8'h06);
		rd_status(8'h05, 8'hff, 8'h02, "latch set");
		cmd(8'h04);
		rd_status(8'h05, 8'hff, 8'h00, "latch cleared");
		cmd(8'h01, 16'h7c42, 16);
		expect_eq("locked write", 0, starts);
	endtask
	task automatic t_write(input [15:0] val, input bit ok, input string what);
		int n;
		n = starts;
		cmd(8'h06);
		cmd(8'h01, val, 16);
		expect_eq(what, 16'(ok), 16'(starts - n));
		if (ok) begin
			rd_status(8'h05, 8'h03, 8'h03, "busy in write");
			pulse(0);
			rd_status(8'h05, 8'hff, val[15:8] & 8'hfc, "status1 after write");
		end
		else cmd(8'h04);
	endtask
	// Erase then program, each suspended and resumed, then two refusals
	task automatic t_array;
		int n;
		for (int k = 0; k < 2; k++) begin
			cmd(8'h06);
			cmd(k ? 8'h02 : 8'h20, k ? 32'h000100a5 : 32'h00001000, k ? 32 : 24);
			expect_eq("array code", k ? 8'h02 : 8'h20, op_code_out);
			pulse(1);
			rd_status(8'h09, k ? 8'h04 : 8'h80, 8'hff, "paused flag");
			pulse(2);
			rd_status(8'h35, 8'h84, 8'h00, "paused flag cleared");
			pulse(0);
			rd_status(8'h05, 8'h03, 8'h00, "array done");
		end
		n = starts;
		#1 target_protected_in = 1'b1;
		cmd(8'h06);
		cmd(8'h20, 0, 24);
		#1 target_protected_in = 1'b0;
		cmd(8'hc7);
		expect_eq("refused array ops", n, starts);
		cmd(8'h04);
	endtask

	// Bound the run: about 43 frames of under 200 cycles each
	initial begin
		#400000;
		mismatches++;
		tally_and_finish;
	end
	initial begin
		repeat (5) @(posedge sys_clk_in);
		#1 nrst_in = 1'b1;
		t_reset;
		t_latch;
		t_write(16'h7c42, 1, "first write");
		rd_status(8'h35, 8'hff, 8'h42, "status2 after write");
		expect_eq("protect view", 16'h3f, {region_size_out, protect_from_low_end_out,
			small_granule_lock_out, invert_protect_region_out});
		t_array;
		t_write(16'h8038, 1, "lock write");
		expect_eq("locks and guard", 16'hf, {otp_lock_out, guard_pin_active_out});
		#1 write_guard_n_in = 1'b0;
		t_write(16'h0002, 0, "guarded write");
		rd_status(8'h05, 8'hff, 8'h80, "status1 read-only");
		#1 write_guard_n_in = 1'b1;
		t_write(16'h0002, 1, "unguarded write");
		rd_status(8'h09, 8'hff, 8'h3a, "locks kept");
		cmd(8'h06);
		cmd(8'h60);
		expect_eq("chip wipe accepted", 8'h60, op_code_out);
		pulse(0);
		#1 four_wire_cmd_mode_in = 1'b1;
		rd_status(8'h35, 8'hfe, 8'h3a, "status2 nibbles");
		tally_and_finish;
	end
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
endmodule
